// File: verilog/edsc_defs.vh
// constants for the end device sleep controller
`ifndef EDSC_DEFS_VH
`define EDSC_DEFS_VH

// wishbone register byte offsets
`define EDSC_REG_MODE 8'h00
`define EDSC_REG_PERIOD 8'h04
`define EDSC_REG_MULT 8'h08
`define EDSC_REG_WAKE 8'h0c
`define EDSC_REG_OPTS 8'h10
`define EDSC_REG_CMD 8'h14
`define EDSC_REG_STATUS 8'h18

// sleep mode values
`define EDSC_SM_PIN 3'h1
`define EDSC_SM_CYC 3'h4
`define EDSC_SM_CYC_PIN 3'h5

// option bits
`define EDSC_OPT_FULL_WAKE 1
`define EDSC_OPT_EXTENDED 2

// limits of the period and multiplier settings
`define EDSC_PERIOD_MIN 12'h020
`define EDSC_PERIOD_MAX 12'haf0
`define EDSC_MULT_MIN 16'h0001

// reset values
`define EDSC_RST_MODE 3'h0
`define EDSC_RST_PERIOD 12'h020
`define EDSC_RST_MULT 16'h0001
`define EDSC_RST_WAKE 16'h1388
`define EDSC_RST_OPTS 8'h00

// time bases
`define EDSC_CLK_HZ 100000000
`define EDSC_TICK_MS 10
`define EDSC_POLL_MS 100

// command register bits
`define EDSC_CMD_SLEEP_NOW 0

`endif

// File: verilog/edsc_sleep_ctrl.v
// sleep and wake sequencer for a low power end device
//
// Register access over Wishbone and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "edsc_defs.vh"

// Contract
// - mode 1: pin level decides sleep
// - finish transmit or receive before sleeping
// - defer sleep until join attempt completes
// - pin low wakes device in pin sleep
// - awake and joined: poll every 100ms
// - modes 4 and 5: timed cyclic sleep
// - mode 5 pin falling edge wakes
// - poll after wake; stay if data
// - awake indicator high awake, low asleep; in modes 4 and 5 it stays low after a wake until radio data arrives
// - flow control: cts low awake, high asleep
// - data starts and restarts wake timer
// - timer expiry or sleep-now returns sleep
// - period 0x20 to 0xAF0, 10ms units
// - multiplier accepts 1 to 0xFFFF
// - option 0x02 full wake, 0x04 extended
// - short cyclic: sleep one period
// - parent data: start timer, keep polling
// - multiplier gates awake indicator per cycles; here cycles are counted but no mode 4 or 5 wake raises the indicator
// - radio data on silent poll asserts indicator
// - extended: sleep period times multiplier
// - transmit only awake and joined
// - asleep: ignore serial and radio input
// - unjoined wake starts channel scan
// - no timer: poll once then sleep
module edsc_sleep_ctrl #(
    parameter TICK_CYCLES = (`EDSC_CLK_HZ / 1000) * `EDSC_TICK_MS,
    parameter POLL_TICKS = `EDSC_POLL_MS / `EDSC_TICK_MS
) (
    // clock and reset
    input wire clock,
    input wire rstn,
    // wishbone slave
    input wire wbCyc,
    input wire wbStb,
    input wire wbWe,
    input wire [7:0] wbAdr,
    input wire [3:0] wbSel,
    input wire [31:0] wbDatI,
    output reg [31:0] wbDatO,
    output reg wbAck,
    // host pins
    input wire sleepRequestInput,
    output reg awakeIndicator,
    output reg ctsN,
    // radio stack
    input wire joined,
    input wire joinBusy,
    input wire txRxBusy,
    input wire pollAck,
    input wire parentHasData,
    input wire radioDataRx,
    input wire serialDataRx,
    input wire txRequest,
    output reg pollRequest,
    output reg scanStart,
    output reg txGrant,
    output reg radioEnable
);

    // ************************************************************
    // state and registers
    // ************************************************************
    localparam S_AWAKE = 2'h0;
    localparam S_DRAIN = 2'h1;
    localparam S_SLEEP = 2'h2;
    localparam [7:0] POLL_LAST = POLL_TICKS - 1;

    reg [1:0] state_r;
    reg [2:0] sleepModeSetting_r;
    reg [11:0] sleepPeriodSetting_r;
    reg [15:0] periodMultiplierSetting_r;
    reg [15:0] wakeTimeSetting_r;
    reg [7:0] sleepOptions_r;
    reg flowControlEnableSetting_r;
    reg sleepNow_r;
    reg [31:0] tickDiv_r;
    reg [27:0] sleepCnt_r;
    reg [15:0] wakeCnt_r;
    reg wakeTimerOn_r;
    reg [7:0] pollCnt_r;
    reg polledOnce_r;
    reg pollPending_r;
    reg [15:0] cycleCnt_r;
    reg indicate_r;
    reg reqSync1_r;
    reg reqSync2_r;
    reg reqPrev_r;

    wire tick = (tickDiv_r == TICK_CYCLES - 1);
    wire modePin = (sleepModeSetting_r == `EDSC_SM_PIN);
    wire modeCyc = (sleepModeSetting_r == `EDSC_SM_CYC) ||
        (sleepModeSetting_r == `EDSC_SM_CYC_PIN);
    wire extended = sleepOptions_r[`EDSC_OPT_EXTENDED];
    wire fullWake = sleepOptions_r[`EDSC_OPT_FULL_WAKE];
    wire pinFall = reqPrev_r & ~reqSync2_r;
    wire awake = (state_r != S_SLEEP);
    // asleep, all incoming data is dropped
    wire rxEvent = awake & (radioDataRx | serialDataRx);
    wire busy = txRxBusy | joinBusy | pollPending_r;

    // extended sleep lasts period times multiplier ticks
    wire [27:0] sleepLen = extended ?
        sleepPeriodSetting_r * periodMultiplierSetting_r :
        {16'h0000, sleepPeriodSetting_r};

    // ************************************************************
    // clamp helpers
    // ************************************************************
    function [11:0] clampPeriod;
        input [31:0] v;
        begin
            if (v[11:0] < `EDSC_PERIOD_MIN || v[31:12] != 20'h00000) begin
                clampPeriod = (v[31:12] != 20'h00000) ? `EDSC_PERIOD_MAX : `EDSC_PERIOD_MIN;
            end else if (v[11:0] > `EDSC_PERIOD_MAX) begin
                clampPeriod = `EDSC_PERIOD_MAX;
            end else begin
                clampPeriod = v[11:0];
            end
        end
    endfunction

    // ************************************************************
    // pin synchroniser
    // ************************************************************
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            reqSync1_r <= 1'b0;
            reqSync2_r <= 1'b0;
            reqPrev_r <= 1'b0;
        end else begin
            reqSync1_r <= sleepRequestInput;
            reqSync2_r <= reqSync1_r;
            reqPrev_r <= reqSync2_r;
        end
    end

    // ************************************************************
    // wishbone registers
    // ************************************************************
    wire wbHit = wbCyc & wbStb & ~wbAck;
    wire wbWr = wbHit & wbWe & wbSel[0];

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wbAck <= 1'b0;
            wbDatO <= 32'h00000000;
            sleepModeSetting_r <= `EDSC_RST_MODE;
            sleepPeriodSetting_r <= `EDSC_RST_PERIOD;
            periodMultiplierSetting_r <= `EDSC_RST_MULT;
            wakeTimeSetting_r <= `EDSC_RST_WAKE;
            sleepOptions_r <= `EDSC_RST_OPTS;
            flowControlEnableSetting_r <= 1'b0;
            sleepNow_r <= 1'b0;
        end else begin
            wbAck <= wbHit;
            sleepNow_r <= 1'b0;
            if (wbWr) begin
                case (wbAdr)
                    `EDSC_REG_MODE: begin
                        sleepModeSetting_r <= wbDatI[2:0];
                        flowControlEnableSetting_r <= wbDatI[8];
                    end
                    `EDSC_REG_PERIOD: sleepPeriodSetting_r <= clampPeriod(wbDatI);
                    `EDSC_REG_MULT: begin
                        // zero is outside the range and is held at one
                        periodMultiplierSetting_r <= (wbDatI[15:0] == 16'h0000) ?
                            `EDSC_MULT_MIN : wbDatI[15:0];
                    end
                    `EDSC_REG_WAKE: wakeTimeSetting_r <= wbDatI[15:0];
                    `EDSC_REG_OPTS: sleepOptions_r <= wbDatI[7:0];
                    `EDSC_REG_CMD: sleepNow_r <= wbDatI[`EDSC_CMD_SLEEP_NOW];
                    default: ;
                endcase
            end
            if (wbHit && !wbWe) begin
                case (wbAdr)
                    `EDSC_REG_MODE: wbDatO <= {23'h000000, flowControlEnableSetting_r,
                        5'h00, sleepModeSetting_r};
                    `EDSC_REG_PERIOD: wbDatO <= {20'h00000, sleepPeriodSetting_r};
                    `EDSC_REG_MULT: wbDatO <= {16'h0000, periodMultiplierSetting_r};
                    `EDSC_REG_WAKE: wbDatO <= {16'h0000, wakeTimeSetting_r};
                    `EDSC_REG_OPTS: wbDatO <= {24'h000000, sleepOptions_r};
                    `EDSC_REG_STATUS: wbDatO <= {8'h00, cycleCnt_r, 1'b0,
                        wakeTimerOn_r, indicate_r, joined, 2'h0, state_r};
                    default: wbDatO <= 32'h00000000;
                endcase
            end else begin
                wbDatO <= 32'h00000000;
            end
        end
    end

    // ************************************************************
    // sequencer
    // ************************************************************
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_r <= S_AWAKE;
            tickDiv_r <= 32'h00000000;
            sleepCnt_r <= 28'h0000000;
            wakeCnt_r <= 16'h0000;
            wakeTimerOn_r <= 1'b0;
            pollCnt_r <= 8'h00;
            polledOnce_r <= 1'b0;
            pollPending_r <= 1'b0;
            cycleCnt_r <= 16'h0000;
            indicate_r <= 1'b1;
            pollRequest <= 1'b0;
            scanStart <= 1'b0;
            txGrant <= 1'b0;
            radioEnable <= 1'b1;
            awakeIndicator <= 1'b1;
            ctsN <= 1'b1;
        end else begin
            tickDiv_r <= tick ? 32'h00000000 : tickDiv_r + 32'h00000001;
            pollRequest <= 1'b0;
            scanStart <= 1'b0;
            if (pollAck) begin
                pollPending_r <= 1'b0;
            end
            case (state_r)
                S_AWAKE: begin
                    // polls every 100 ms while joined, but only once in cyclic mode while the wake timer is off
                    if (joined && tick) begin
                        // a switch into cyclic mode while awake still owes one poll
                        if ((pollCnt_r == 8'h00 || (modeCyc && !polledOnce_r)) &&
                            !(modeCyc && polledOnce_r && !wakeTimerOn_r)) begin
                            pollRequest <= 1'b1;
                            pollPending_r <= 1'b1;
                            polledOnce_r <= modeCyc;
                        end
                        pollCnt_r <= (pollCnt_r == POLL_LAST) ?
                            8'h00 : pollCnt_r + 8'h01;
                    end
                    if (modeCyc) begin
                        if (rxEvent || (pollAck && parentHasData) ||
                            (fullWake && !wakeTimerOn_r && !polledOnce_r)) begin
                            wakeTimerOn_r <= 1'b1;
                            wakeCnt_r <= wakeTimeSetting_r;
                        end else if (wakeTimerOn_r && tick && wakeCnt_r != 16'h0000) begin
                            wakeCnt_r <= wakeCnt_r - 16'h0001;
                        end
                        if (radioDataRx) begin
                            indicate_r <= 1'b1;
                        end
                        if (sleepNow_r ||
                            (wakeTimerOn_r && wakeCnt_r == 16'h0000) ||
                            (polledOnce_r && !wakeTimerOn_r && pollAck && !parentHasData &&
                            !rxEvent)) begin
                            state_r <= S_DRAIN;
                        end
                    end else if (modePin && reqSync2_r) begin
                        state_r <= S_DRAIN;
                    end
                end
                S_DRAIN: begin
                    // transfers and any join scan finish before sleep
                    if (modePin && !reqSync2_r) begin
                        state_r <= S_AWAKE;
                    end else if (!busy) begin
                        state_r <= S_SLEEP;
                        sleepCnt_r <= sleepLen;
                        wakeTimerOn_r <= 1'b0;
                        polledOnce_r <= 1'b0;
                    end
                end
                S_SLEEP: begin
                    if (tick && sleepCnt_r != 28'h0000000) begin
                        sleepCnt_r <= sleepCnt_r - 28'h0000001;
                    end
                    if ((modePin && !reqSync2_r) ||
                        (modeCyc && sleepCnt_r == 28'h0000000) ||
                        (sleepModeSetting_r == `EDSC_SM_CYC_PIN && pinFall) ||
                        (!modePin && !modeCyc)) begin
                        state_r <= S_AWAKE;
                        pollCnt_r <= 8'h00;
                        scanStart <= ~joined;
                        if (periodMultiplierSetting_r == `EDSC_MULT_MIN ||
                            cycleCnt_r + 16'h0001 >= periodMultiplierSetting_r) begin
                            indicate_r <= 1'b1;
                            cycleCnt_r <= 16'h0000;
                        end else begin
                            cycleCnt_r <= cycleCnt_r + 16'h0001;
                        end
                    end
                end
                default: state_r <= S_AWAKE;
            endcase
            if (state_r == S_DRAIN && !busy && !(modePin && !reqSync2_r)) begin
                indicate_r <= modePin || !modeCyc;
            end
            if (state_r == S_SLEEP && modeCyc) begin
                indicate_r <= 1'b0;
            end
            awakeIndicator <= awake & (indicate_r | ~modeCyc);
            ctsN <= ~(awake & flowControlEnableSetting_r) | ~flowControlEnableSetting_r;
            txGrant <= awake & joined & txRequest;
            radioEnable <= awake;
        end
    end

endmodule // edsc_sleep_ctrl

// File: dv/edsc_sleep_checker.sv
// port checker for the end device sleep controller
`timescale 1ns/1ns
`include "edsc_defs.vh"
module edsc_sleep_checker #(
    parameter TICK_CYCLES = 10,
    parameter POLL_TICKS = 10
) (
    // clock and reset
    input wire clock,
    input wire rstn,
    // wishbone
    input wire wbCyc,
    input wire wbStb,
    input wire wbWe,
    input wire [7:0] wbAdr,
    input wire [3:0] wbSel,
    input wire [31:0] wbDatI,
    input wire wbAck,
    // pins and stack
    input wire sleepRequestInput,
    input wire awakeIndicator,
    input wire ctsN,
    input wire joined,
    input wire txRequest,
    input wire pollRequest,
    input wire scanStart,
    input wire txGrant,
    input wire radioEnable
);
    // ****************
    // helper state
    // ****************
    localparam int GAP_MAX = POLL_TICKS * TICK_CYCLES + 2 * TICK_CYCLES + 4;
    reg [2:0] modeR;
    reg [15:0] gapR;
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            modeR <= 3'h0;
        end else if (wbAck && wbWe && wbSel[0] && wbAdr == `EDSC_REG_MODE) begin
            modeR <= wbDatI[2:0];
        end
    end
    // drain and sleep pause the poll clock; the gap restarts in sleep and while the sleep pin is high
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            gapR <= 16'h0;
        end else if (pollRequest || !radioEnable || !joined || sleepRequestInput) begin
            gapR <= 16'h0;
        end else begin
            gapR <= gapR + 16'h1;
        end
    end
    default clocking dc @(posedge clock); endclocking
    default disable iff (!rstn);
    property p_ackOne; (wbCyc && wbStb && !wbAck) |=> wbAck ##1 !wbAck; endproperty
    a_ackOne: assert property (p_ackOne) else $error("ack not one cycle after request");
    property p_grant; txGrant |-> radioEnable && $past(joined && txRequest); endproperty
    a_grant: assert property (p_grant) else $error("grant while not allowed");
    property p_quiet; (!radioEnable && $past(!radioEnable)) |-> !pollRequest && !txGrant;
    endproperty
    a_quiet: assert property (p_quiet) else $error("activity while asleep");
    property p_sleepInd; !radioEnable |-> !awakeIndicator; endproperty
    a_sleepInd: assert property (p_sleepInd) else $error("indicator high asleep");
    property p_sleepCts; !radioEnable |-> ctsN; endproperty
    a_sleepCts: assert property (p_sleepCts) else $error("cts low asleep");
    property p_pollSpace; pollRequest |=> !pollRequest [*8]; endproperty
    a_pollSpace: assert property (p_pollSpace) else $error("polls too close");
    property p_pollGap; gapR <= GAP_MAX; endproperty
    a_pollGap: assert property (p_pollGap) else $error("poll overdue");
    property p_scan; scanStart |-> !$past(joined); endproperty
    a_scan: assert property (p_scan) else $error("scan while joined");
    property p_awakeModes; (modeR != 3'h1 && modeR != 3'h4 && modeR != 3'h5) [*8] |-> radioEnable;
    endproperty
    a_awakeModes: assert property (p_awakeModes) else $error("asleep in awake mode");
    property p_pinWake; (modeR == 3'h1 && !sleepRequestInput) [*8] |-> radioEnable; endproperty
    a_pinWake: assert property (p_pinWake) else $error("no wake on pin low");
endmodule // edsc_sleep_checker

bind edsc_sleep_ctrl edsc_sleep_checker #(.TICK_CYCLES(TICK_CYCLES), .POLL_TICKS(POLL_TICKS))
    chk (.clock, .rstn, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatI, .wbAck,
    .sleepRequestInput, .awakeIndicator, .ctsN, .joined, .txRequest, .pollRequest,
    .scanStart, .txGrant, .radioEnable);

// File: dv/edsc_stack_model.sv
// parent stand-in that answers polls after a set delay
`timescale 1ns/1ns
module edsc_stack_model (
    // clock and reset
    input wire clock,
    input wire rstn,
    // knobs
    input wire [3:0] ackDelay,
    input wire hasData,
    // controller side
    input wire pollRequest,
    output reg pollAck,
    output reg parentHasData
);
    reg [3:0] waitR;
    reg busyR;
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            waitR <= 4'h0;
            busyR <= 1'b0;
            pollAck <= 1'b0;
            parentHasData <= 1'b0;
        end else begin
            pollAck <= 1'b0;
            // flag wanders outside an ack so nobody may trust it there
            parentHasData <= ~parentHasData;
            if (pollRequest) begin
                busyR <= 1'b1;
                waitR <= ackDelay;
            end else if (busyR && waitR == 4'h0) begin
                busyR <= 1'b0;
                pollAck <= 1'b1;
                parentHasData <= hasData;
            end else if (busyR) begin
                waitR <= waitR - 4'h1;
            end
        end
    end
endmodule // edsc_stack_model

// File: dv/edsc_sleep_ctrl_bench.sv
// self-checking bench for the end device sleep controller
`timescale 1ns/1ns
`include "edsc_defs.vh"
module edsc_sleep_ctrl_bench;
    reg clock = 0, rstn = 0, wbCyc = 0, wbStb = 0, wbWe = 0, sleepRequestInput = 0;
    reg joined = 0, joinBusy = 0, txRxBusy = 0, radioDataRx = 0, serialDataRx = 0;
    reg txRequest = 0, hasData = 0, sawScan = 0;
    reg [7:0] wbAdr = 0;
    reg [31:0] wbDatI = 0, rv;
    reg [3:0] ackDelay = 4'h1;
    wire [31:0] wbDatO;
    wire wbAck, awakeIndicator, ctsN, pollAck, parentHasData, pollRequest, scanStart;
    wire txGrant, radioEnable;
    reg [31:0] expQ[$], mskQ[$];
    integer errors = 0, tests_run = 0, cyc = 0, n = 0;
    edsc_sleep_ctrl #(.TICK_CYCLES(10), .POLL_TICKS(10)) uut (.clock, .rstn, .wbCyc, .wbStb,
        .wbWe, .wbAdr, .wbSel(4'hf), .wbDatI, .wbDatO, .wbAck, .sleepRequestInput,
        .awakeIndicator, .ctsN, .joined, .joinBusy, .txRxBusy, .pollAck, .parentHasData,
        .radioDataRx, .serialDataRx, .txRequest, .pollRequest, .scanStart, .txGrant,
        .radioEnable);
    edsc_stack_model partner (.clock, .rstn, .ackDelay, .hasData, .pollRequest, .pollAck,
        .parentHasData);
    initial begin
        forever #5 clock = ~clock;
    end
    task print_verdict;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task cmpWord(input [31:0] got, input [31:0] exp, input [31:0] msk);
        tests_run = tests_run + 1;
        if ((got & msk) !== exp) begin
            errors = errors + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got & msk, exp);
        end
    endtask
    task cmpBit(input got, input exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task xfer(input we, input [7:0] adr, input [31:0] dat);
        @(posedge clock);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbDatI <= dat;
        do @(posedge clock); while (wbAck !== 1'b1);
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask
    task wr(input [7:0] adr, input [31:0] dat);
        xfer(1'b1, adr, dat);
    endtask
    task rd(input [7:0] adr, input [31:0] exp, input [31:0] msk);
        expQ.push_back(exp);
        mskQ.push_back(msk);
        xfer(1'b0, adr, 32'h0);
    endtask
    task waitEn(input lvl, input integer lim);
        n = 0;
        while (radioEnable !== lvl && n < lim) begin
            @(posedge clock);
            n = n + 1;
        end
    endtask
    // ****************
    // read scoreboard and hang guard
    // ****************
    always @(posedge clock) begin
        cyc = cyc + 1;
        if (wbAck === 1'b1 && wbWe === 1'b0 && expQ.size() > 0)
            cmpWord(wbDatO, expQ.pop_front(), mskQ.pop_front());
        if (scanStart === 1'b1) sawScan = 1'b1;
        if (cyc > 20000) begin
            errors = errors + 1;
            print_verdict;
        end
    end
    initial begin
        rv = $urandom(32'he601c0c7);
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        cmpBit(awakeIndicator, 1'b1);
        cmpBit(ctsN, 1'b1);
        rd(`EDSC_REG_PERIOD, 32'h20, 32'hffffffff);
        rd(`EDSC_REG_WAKE, 32'h1388, 32'hffffffff);
        rd(8'hfc, 32'h0, 32'hffffffff);
        wr(`EDSC_REG_PERIOD, 32'h1f);
        rd(`EDSC_REG_PERIOD, 32'h20, 32'hffffffff);
        wr(`EDSC_REG_PERIOD, 32'hfff);
        rd(`EDSC_REG_PERIOD, 32'haf0, 32'hffffffff);
        wr(`EDSC_REG_MULT, 32'h0);
        rd(`EDSC_REG_MULT, 32'h1, 32'hffffffff);
        rv = 32'h20 + $urandom % 32'had1;
        wr(`EDSC_REG_PERIOD, rv);
        rd(`EDSC_REG_PERIOD, rv, 32'hffffffff);
        joined <= 1'b1;
        txRequest <= 1'b1;
        sleepRequestInput <= 1'b1;
        txRxBusy <= 1'b1;
        repeat (250) @(posedge clock);
        cmpBit(txGrant, 1'b1);
        cmpBit(radioEnable, 1'b1);
        wr(`EDSC_REG_MODE, 32'h101);
        repeat (20) @(posedge clock);
        rd(`EDSC_REG_STATUS, 32'h1, 32'h3);
        txRxBusy <= 1'b0;
        waitEn(1'b0, 100);
        cmpBit(n < 100, 1'b1);
        rd(`EDSC_REG_STATUS, 32'h2, 32'h3);
        sleepRequestInput <= 1'b0;
        waitEn(1'b1, 20);
        repeat (2) @(posedge clock);
        cmpBit(ctsN, 1'b0);
        cmpBit(awakeIndicator, 1'b1);
        joined <= 1'b0;
        joinBusy <= 1'b1;
        sleepRequestInput <= 1'b1;
        repeat (30) @(posedge clock);
        rd(`EDSC_REG_STATUS, 32'h1, 32'h3);
        joinBusy <= 1'b0;
        waitEn(1'b0, 100);
        cmpBit(n < 100, 1'b1);
        sawScan = 1'b0;
        sleepRequestInput <= 1'b0;
        waitEn(1'b1, 20);
        repeat (3) @(posedge clock);
        cmpBit(sawScan, 1'b1);
        joined <= 1'b1;
        wr(`EDSC_REG_PERIOD, 32'h20);
        wr(`EDSC_REG_WAKE, 32'h2);
        wr(`EDSC_REG_MODE, 32'h104);
        waitEn(1'b0, 300);
        cmpBit(n < 300, 1'b1);
        waitEn(1'b1, 400);
        cmpBit(n >= 300 && n <= 345, 1'b1);
        waitEn(1'b0, 300);
        sleepRequestInput <= 1'b1;
        serialDataRx <= 1'b1;
        @(posedge clock);
        serialDataRx <= 1'b0;
        repeat (3) @(posedge clock);
        sleepRequestInput <= 1'b0;
        repeat (20) @(posedge clock);
        cmpBit(radioEnable, 1'b0);
        wr(`EDSC_REG_MODE, 32'h105);
        waitEn(1'b1, 400);
        waitEn(1'b0, 300);
        ackDelay <= 4'($urandom % 4);
        sleepRequestInput <= 1'b1;
        repeat (4) @(posedge clock);
        sleepRequestInput <= 1'b0;
        waitEn(1'b1, 20);
        cmpBit(n < 20, 1'b1);
        radioDataRx <= 1'b1;
        @(posedge clock);
        radioDataRx <= 1'b0;
        repeat (8) @(posedge clock);
        rd(`EDSC_REG_STATUS, 32'h40, 32'h40);
        wr(`EDSC_REG_CMD, 32'h1);
        waitEn(1'b0, 10);
        cmpBit(n < 10, 1'b1);
        wr(`EDSC_REG_MULT, 32'h2);
        wr(`EDSC_REG_OPTS, 32'h6);
        waitEn(1'b1, 800);
        waitEn(1'b0, 400);
        waitEn(1'b1, 800);
        cmpBit(n >= 620 && n <= 665, 1'b1);
        print_verdict;
    end
endmodule // edsc_sleep_ctrl_bench
